// file: include/ewg_cfg.svh
`ifndef EWG_CFG_SVH
`define EWG_CFG_SVH

// Memory-mapped register word addresses.
`define EWG_ADDR_PAGE 16'h001e
`define EWG_ADDR_WSC 16'h0028
`define EWG_ADDR_WCTL 16'h002b

// Field positions in wait_state_counts.
`define EWG_XPA_BIT 15
`define EWG_IO_LSB 12
`define EWG_DHI_LSB 9
`define EWG_DLO_LSB 6
`define EWG_PHI_LSB 3
`define EWG_PLO_LSB 0
`define EWG_FIELD_W 3

// Field position in wait_state_control.
`define EWG_WAIT_MULTIPLIER_BIT_BIT 0

// Reset values.
`define EWG_RST_PAGE 16'h0000
`define EWG_RST_WSC 16'h7fff
`define EWG_RST_WCTL 16'h0000

// Address geometry.
`define EWG_PAGE_W 4
`define EWG_OFS_W 16
`define EWG_XADDR_W 20
`define EWG_OVL_TOP 2'b00

`endif

// file: include/ewg_pkg.sv
package ewg_pkg;

  typedef enum logic [1:0] {
    EWG_SPACE_PROG,
    EWG_SPACE_DATA,
    EWG_SPACE_IO
  } ewg_space_t;

  typedef enum logic {
    EWG_ST_IDLE,
    EWG_ST_CYCLE
  } ewg_state_t;

endpackage

// file: rtl/ewg_wait_counter.sv
`timescale 1ns/100ps
module ewg_wait_counter #(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_resetn,
  // Control.
  input wire logic i_run,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_count,
  // Status.
  output logic o_zero
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic at_zero;

  assign at_zero = (count_reg == '0);

  // With every range at zero waits the counter is frozen at zero, which
  // stands in for stopping its clock.
  always_comb begin
    count_next = count_reg;
    if (!i_run) begin
      count_next = '0;
    end else if (i_load) begin
      count_next = i_count;
    end else if (!at_zero) begin
      count_next = count_reg - WIDTH'(1);
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign o_zero = at_zero;

endmodule

// file: rtl/ewg_top.sv
`timescale 1ns/100ps
`include "ewg_cfg.svh"

module ewg_top (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_resetn,
  // Memory-mapped register port.
  input wire logic i_mmr_wr,
  input wire logic i_mmr_rd,
  input wire logic [15:0] i_mmr_addr,
  input wire logic [15:0] i_mmr_wdata,
  output logic [15:0] o_mmr_rdata,
  // Access request from the core.
  input wire logic i_acc_req,
  input wire ewg_pkg::ewg_space_t i_acc_space,
  input wire logic [15:0] i_acc_addr,
  input wire logic i_acc_wide,
  input wire logic i_acc_far,
  input wire logic [19:0] i_acc_xaddr,
  output logic o_acc_busy,
  output logic o_acc_done,
  output logic o_acc_internal,
  // Memory map state held elsewhere in the core.
  input wire logic i_ram_overlay_bit,
  // External bus.
  input wire logic i_ready,
  output logic o_ext_strobe,
  output ewg_pkg::ewg_space_t o_ext_space,
  output logic [19:0] o_ext_addr
);
  import ewg_pkg::*;

  localparam int FW = `EWG_FIELD_W;
  localparam int CW = FW + 1;

  // Memory-mapped registers and read data.
  logic [15:0] page_reg;
  logic [15:0] page_next;
  logic [15:0] wsc_reg;
  logic [15:0] wsc_next;
  logic [15:0] wctl_reg;
  logic [15:0] wctl_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  // Bus cycle state and the captured access.
  ewg_state_t state_reg;
  ewg_state_t state_next;
  logic strobe_reg;
  logic strobe_next;
  logic done_reg;
  logic done_next;
  logic internal_reg;
  logic internal_next;
  logic [19:0] addr_reg;
  logic [19:0] addr_next;
  ewg_space_t space_reg;
  ewg_space_t space_next;

  // Register decode. Only three word addresses answer; the rest read as
  // zero and ignore writes.
  wire hit_page = (i_mmr_addr == `EWG_ADDR_PAGE);
  wire hit_wsc = (i_mmr_addr == `EWG_ADDR_WSC);
  wire hit_wctl = (i_mmr_addr == `EWG_ADDR_WCTL);
  wire wr_page = i_mmr_wr && hit_page;
  wire wr_wsc = i_mmr_wr && hit_wsc;
  wire wr_wctl = i_mmr_wr && hit_wctl;

  // Wait-count fields, one 3-bit base count per external range. The top
  // bit picks how program addresses share the two program fields.
  wire extended_range_control = wsc_reg[`EWG_XPA_BIT];
  wire [FW-1:0] f_io = wsc_reg[`EWG_IO_LSB +: FW];
  wire [FW-1:0] f_dhi = wsc_reg[`EWG_DHI_LSB +: FW];
  wire [FW-1:0] f_dlo = wsc_reg[`EWG_DLO_LSB +: FW];
  wire [FW-1:0] f_phi = wsc_reg[`EWG_PHI_LSB +: FW];
  wire [FW-1:0] f_plo = wsc_reg[`EWG_PLO_LSB +: FW];
  wire wait_multiplier_bit = wctl_reg[`EWG_WAIT_MULTIPLIER_BIT_BIT];

  // The upper program field counts only while it can be selected, so a
  // stale value there does not keep the counter running.
  wire phi_used = !extended_range_control && (f_phi != '0);
  wire all_zero = (f_io == '0) && (f_dhi == '0) && (f_dlo == '0) &&
                  !phi_used && (f_plo == '0);

  // Program address: wide operations carry all twenty bits, others
  // take the page from the page register.
  wire [`EWG_PAGE_W-1:0] cur_page = page_reg[`EWG_PAGE_W-1:0];
  wire [19:0] prog_addr = i_acc_wide ? i_acc_xaddr :
                          {cur_page, i_acc_addr};
  wire [15:0] prog_ofs = prog_addr[`EWG_OFS_W-1:0];
  wire is_prog = (i_acc_space == EWG_SPACE_PROG);

  // Overlay maps on-chip RAM over the low 16K of each page.
  wire ovl_hit = is_prog && i_ram_overlay_bit &&
                 (prog_ofs[15:14] == `EWG_OVL_TOP);

  // Base count selection per space and range. I/O uses one field for the
  // whole port range; data splits on the top address bit; program splits
  // on the top offset bit only while the extended-range bit is clear.
  wire [FW-1:0] prog_base = (!extended_range_control && prog_ofs[15]) ? f_phi :
                            f_plo;
  wire [FW-1:0] data_base = i_acc_addr[15] ? f_dhi :
                            f_dlo;
  wire [FW-1:0] sel_base = (i_acc_space == EWG_SPACE_IO) ? f_io :
                           (is_prog ? prog_base : data_base);

  // The multiplier bit doubles the base count by a shift, which gives at
  // most fourteen waits from a base of seven.
  wire [CW-1:0] wait_count = wait_multiplier_bit ? {sel_base, 1'b0} :
                             {1'b0, sel_base};

  // Data and I/O addresses leave the four page lines low.
  wire [19:0] ext_addr = is_prog ? prog_addr :
                         {{(20 - `EWG_OFS_W){1'b0}}, i_acc_addr};

  // A request is taken only while idle. An overlay hit is answered from
  // on-chip RAM and never opens a bus cycle.
  wire start = (state_reg == EWG_ST_IDLE) && i_acc_req;
  wire start_ext = start && !ovl_hit;
  wire far_load = start && is_prog && i_acc_far;
  wire cnt_zero;

  // The counter is loaded on the request edge, so the bus cycle lasts one
  // cycle more than the inserted count. With every range at zero it stays
  // frozen at zero, which saves its switching power.
  ewg_wait_counter #(
    .WIDTH(CW)
  ) u_ewg_wait_counter (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_run(!all_zero),
    .i_load(start_ext),
    .i_count(wait_count),
    .o_zero(cnt_zero)
  );

  // A cycle ends only once the waits are spent and ready is high. A slow
  // device can hold ready low for as long as it needs; the strobe stays up.
  wire cycle_end = (state_reg == EWG_ST_CYCLE) && cnt_zero &&
                   i_ready;

  // Register file. A far operation and a page write in the same cycle
  // cannot both land; the far operation wins, because the program flow
  // must follow the page that it has just selected.
  always_comb begin
    page_next = page_reg;
    if (far_load) begin
      page_next = {{(16 - `EWG_PAGE_W){1'b0}},
                   i_acc_xaddr[19:`EWG_OFS_W]};
    end else if (wr_page) begin
      page_next = {{(16 - `EWG_PAGE_W){1'b0}},
                   i_mmr_wdata[`EWG_PAGE_W-1:0]};
    end
  end

  // Every bit of the wait-count register is writable.
  assign wsc_next = wr_wsc ? i_mmr_wdata : wsc_reg;

  // Reserved control bits ignore writes and read as zero.
  assign wctl_next = wr_wctl ?
                     {15'h0000, i_mmr_wdata[`EWG_WAIT_MULTIPLIER_BIT_BIT]} : wctl_reg;

  // Read data is registered and holds until the next read.
  always_comb begin
    rdata_next = rdata_reg;
    if (i_mmr_rd) begin
      if (hit_page) begin
        rdata_next = page_reg;
      end else if (hit_wsc) begin
        rdata_next = wsc_reg;
      end else if (hit_wctl) begin
        rdata_next = wctl_reg;
      end else begin
        rdata_next = 16'h0000;
      end
    end
  end

  // Page register, cleared by reset.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      page_reg <= `EWG_RST_PAGE;
    end else begin
      page_reg <= page_next;
    end
  end

  // Wait-count register; reset gives seven waits on every range.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wsc_reg <= `EWG_RST_WSC;
    end else begin
      wsc_reg <= wsc_next;
    end
  end

  // Wait-state control register; the multiplier starts cleared.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wctl_reg <= `EWG_RST_WCTL;
    end else begin
      wctl_reg <= wctl_next;
    end
  end

  // Read data register.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Bus cycle sequencing. The strobe, space and address are registered
  // together on the request edge and stand until the edge at which the
  // cycle ends; done then pulses for one cycle. A new request may be
  // made in the done cycle.
  always_comb begin
    state_next = state_reg;
    strobe_next = strobe_reg;
    done_next = 1'b0;
    internal_next = 1'b0;
    addr_next = addr_reg;
    space_next = space_reg;
    unique case (state_reg)
      EWG_ST_IDLE: begin
        if (start) begin
          addr_next = ext_addr;
          space_next = i_acc_space;
          if (ovl_hit) begin
            done_next = 1'b1;
            internal_next = 1'b1;
          end else begin
            strobe_next = 1'b1;
            state_next = EWG_ST_CYCLE;
          end
        end
      end
      EWG_ST_CYCLE: begin
        if (cycle_end) begin
          strobe_next = 1'b0;
          done_next = 1'b1;
          state_next = EWG_ST_IDLE;
        end
      end
    endcase
  end

  // Cycle state.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= EWG_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Strobe level, up for the whole bus cycle.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= strobe_next;
    end
  end

  // Done pulse.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
    end
  end

  // Overlay hit flag, pulsed together with done.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      internal_reg <= 1'b0;
    end else begin
      internal_reg <= internal_next;
    end
  end

  // External address. It holds the last address between cycles, but an
  // overlay hit also loads its address while the bus stays idle.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      addr_reg <= 20'h00000;
    end else begin
      addr_reg <= addr_next;
    end
  end

  // Space of the current cycle.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      space_reg <= EWG_SPACE_PROG;
    end else begin
      space_reg <= space_next;
    end
  end

  // Register port.
  assign o_mmr_rdata = rdata_reg;

  // Access handshake.
  assign o_acc_busy = (state_reg == EWG_ST_CYCLE);
  assign o_acc_done = done_reg;
  assign o_acc_internal = internal_reg;

  // External bus.
  assign o_ext_strobe = strobe_reg;
  assign o_ext_space = space_reg;
  assign o_ext_addr = addr_reg;

endmodule

// file: tb/ewg_mem_model.sv
`timescale 1ns/100ps
module ewg_mem_model (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_resetn,
  // Bus side.
  input wire logic i_strobe,
  input wire logic [4:0] i_stall,
  output logic o_ready
);
  logic [4:0] hold_reg;
  // A slow device holds ready low for the first cycles of each bus cycle.
  assign o_ready = !i_strobe || (hold_reg >= i_stall);
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn)
      hold_reg <= 5'h00;
    else if (!i_strobe)
      hold_reg <= 5'h00;
    else if (hold_reg != 5'h1f)
      hold_reg <= hold_reg + 5'h01;
  end
endmodule

// file: tb/ewg_top_monitor.sv
`timescale 1ns/100ps
module ewg_top_monitor
  import ewg_pkg::*;
(
  // Observed ports.
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_mmr_rd,
  input wire logic [15:0] i_mmr_addr,
  input wire logic [15:0] o_mmr_rdata,
  input wire logic i_acc_req,
  input wire ewg_pkg::ewg_space_t i_acc_space,
  input wire logic [15:0] i_acc_addr,
  input wire logic o_acc_busy,
  input wire logic o_acc_done,
  input wire logic o_acc_internal,
  input wire logic i_ready,
  input wire logic o_ext_strobe,
  input wire logic [19:0] o_ext_addr
);
  logic [4:0] run_reg;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn)
      run_reg <= 5'h00;
    else
      run_reg <= (o_ext_strobe && i_ready) ? run_reg + 5'h01 : 5'h00;
  end
  sequence s_take_data;
    i_acc_req && !o_acc_busy && i_acc_space == EWG_SPACE_DATA;
  endsequence
  sequence s_cycle_open;
    o_ext_strobe && o_ext_addr == {4'h0, $past(i_acc_addr)};
  endsequence
  AST_WAIT_MAX: assert property (run_reg <= 5'h0f)
    else $error("bus cycle longer than fourteen waits");
  AST_DONE_READY: assert property (
    o_acc_done && !o_acc_internal |-> $past(i_ready))
    else $error("cycle ended without ready");
  AST_FALL_DONE: assert property (
    $fell(o_ext_strobe) |-> o_acc_done)
    else $error("strobe fell without done");
  AST_DATA_ADDR: assert property (s_take_data |=> s_cycle_open)
    else $error("data cycle address wrong");
  AST_BUSY: assert property (o_ext_strobe |-> o_acc_busy)
    else $error("strobe without busy");
  AST_INT: assert property (
    o_acc_internal |-> o_acc_done && !o_ext_strobe)
    else $error("internal hit drove the bus");
  AST_UNMAP: assert property (
    i_mmr_rd && i_mmr_addr != 16'h001e && i_mmr_addr != 16'h0028 &&
    i_mmr_addr != 16'h002b |=> o_mmr_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_CTL: assert property (
    i_mmr_rd && i_mmr_addr == 16'h002b |=> o_mmr_rdata[15:1] == 15'h0000)
    else $error("control bits set");
endmodule

// file: tb/ewg_top_tb.sv
`timescale 1ns/100ps
module ewg_top_tb;
  import ewg_pkg::*;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic i_mmr_wr = 1'b0;
  logic i_mmr_rd = 1'b0;
  logic [15:0] i_mmr_addr = 16'h0000;
  logic [15:0] i_mmr_wdata = 16'h0000;
  logic [15:0] o_mmr_rdata;
  logic i_acc_req = 1'b0;
  ewg_space_t i_acc_space = EWG_SPACE_PROG;
  logic [15:0] i_acc_addr = 16'h0000;
  logic i_acc_wide = 1'b0;
  logic i_acc_far = 1'b0;
  logic [19:0] i_acc_xaddr = 20'h00000;
  logic o_acc_busy;
  logic o_acc_done;
  logic o_acc_internal;
  logic i_ram_overlay_bit = 1'b0;
  logic i_ready;
  logic o_ext_strobe;
  ewg_space_t o_ext_space;
  logic [19:0] o_ext_addr;
  logic [4:0] stall = 5'h00;
  int error_cnt = 0;
  int checked = 0;
  ewg_space_t tsp [5] = '{EWG_SPACE_IO, EWG_SPACE_DATA, EWG_SPACE_DATA,
    EWG_SPACE_PROG, EWG_SPACE_PROG};
  logic [15:0] tad [5] = '{16'hffff, 16'h8000, 16'h7fff, 16'h8000, 16'h7fff};
  always #12.5 i_clock = ~i_clock;
  ewg_top u_ewg_top (.*);
  ewg_mem_model u_ewg_mem_model (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_strobe(o_ext_strobe), .i_stall(stall), .o_ready(i_ready));
  task automatic end_sim();
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string name, logic [19:0] exp, logic [19:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge i_clock);
    i_mmr_wr <= 1'b1;
    i_mmr_addr <= a;
    i_mmr_wdata <= d;
    @(posedge i_clock);
    i_mmr_wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] e);
    @(posedge i_clock);
    i_mmr_rd <= 1'b1;
    i_mmr_addr <= a;
    @(posedge i_clock);
    i_mmr_rd <= 1'b0;
    #1 chk("rdata", {4'h0, e}, {4'h0, o_mmr_rdata});
  endtask
  // Counts the request cycle and each cycle after it up to done.
  task automatic acc(ewg_space_t sp, logic [15:0] a, logic wd, logic fr,
      logic [19:0] xa, int n, logic [19:0] ea, logic ei);
    int cnt;
    logic [19:0] seen;
    cnt = 1;
    @(posedge i_clock);
    i_acc_req <= 1'b1;
    i_acc_space <= sp;
    i_acc_addr <= a;
    i_acc_wide <= wd;
    i_acc_far <= fr;
    i_acc_xaddr <= xa;
    @(posedge i_clock);
    i_acc_req <= 1'b0;
    #1 seen = o_ext_addr;
    while (o_acc_done !== 1'b1 && cnt < 40) begin
      @(posedge i_clock);
      #1 cnt++;
    end
    if (o_acc_done !== 1'b1) begin
      chk("done", 20'h00001, {19'h00000, o_acc_done});
      end_sim();
    end else begin
      chk("cycles", 20'(n), 20'(cnt));
      chk("internal", {19'h00000, ei}, {19'h00000, o_acc_internal});
      if (!ei)
        chk("ext_addr", ea, seen);
    end
  endtask
  initial begin
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'b1;
    rd(16'h0028, 16'h7fff);
    rd(16'h001e, 16'h0000);
    rd(16'h002b, 16'h0000);
    rd(16'h0029, 16'h0000);
    acc(EWG_SPACE_DATA, 16'h8000, 0, 0, 0, 9, 20'h08000, 0);
    wr(16'h0028, 16'h14e5);
    rd(16'h0028, 16'h14e5);
    for (int m = 0; m < 2; m++) begin
      wr(16'h002b, m ? 16'hffff : 16'h0000);
      for (int i = 0; i < 5; i++) begin
        acc(tsp[i], tad[i], 0, 0, 0, (i + 1) * (m + 1) + 2,
          {4'h0, tad[i]}, 0);
      end
    end
    rd(16'h002b, 16'h0001);
    wr(16'h0028, 16'h94e5);
    acc(EWG_SPACE_PROG, 16'h8000, 0, 0, 0, 12, 20'h08000, 0);
    wr(16'h0028, 16'h7fff);
    acc(EWG_SPACE_IO, 16'h1234, 0, 0, 0, 16, 20'h01234, 0);
    @(posedge i_clock) stall <= 5'h14;
    acc(EWG_SPACE_IO, 16'h1234, 0, 0, 0, 22, 20'h01234, 0);
    @(posedge i_clock) stall <= 5'h00;
    wr(16'h001e, 16'hfff3);
    rd(16'h001e, 16'h0003);
    acc(EWG_SPACE_PROG, 16'h4000, 0, 0, 0, 16, 20'h34000, 0);
    acc(EWG_SPACE_PROG, 0, 1, 1, 20'h9c000, 16, 20'h9c000, 0);
    rd(16'h001e, 16'h0009);
    acc(EWG_SPACE_PROG, 0, 1, 0, 20'h51234, 16, 20'h51234, 0);
    rd(16'h001e, 16'h0009);
    @(posedge i_clock) i_ram_overlay_bit <= 1'b1;
    acc(EWG_SPACE_PROG, 16'h2000, 0, 0, 0, 1, 0, 1);
    acc(EWG_SPACE_DATA, 16'h2000, 0, 0, 0, 16, 20'h02000, 0);
    @(posedge i_clock) i_ram_overlay_bit <= 1'b0;
    wr(16'h0028, 16'h0000);
    acc(EWG_SPACE_PROG, 16'h8000, 0, 0, 0, 2, 20'h98000, 0);
    end_sim();
  end
endmodule
bind ewg_top ewg_top_monitor u_ewg_top_monitor (.*);
